// *** design/pss_pkg.sv ***
// constants and types shared by the power start-up/shut-down sequencer
package pss_pkg;
  // apb geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_VSET = 8'h08;
  // control register bits
  localparam int CTRL_SHUTDOWN = 0;
  localparam int CTRL_LATE_EN = 1;
  // status register bits
  localparam int ST_LOWBAT = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_PG = 2;
  localparam int ST_HS = 3;
  localparam int ST_STATE = 4;
  // supply indices in the enable vector
  localparam int NUM_SUP = 4;
  localparam logic [1:0] SUP_STEPUP = 2'h0;
  localparam logic [1:0] SUP_STEPDOWN = 2'h1;
  localparam logic [1:0] SUP_LIN_A = 2'h2;
  localparam logic [1:0] SUP_LIN_B = 2'h3;
  // start-up sequence: three supplies, steps numbered from zero
  localparam logic [1:0] LAST_STEP = 2'h2;
  // settle time between steps in oscillator cycles, rounded up to pclk
  localparam int OSC_KHZ = 900;
  localparam int CLK_KHZ = 100000;
  localparam int SETTLE_OSC = 8;
  localparam int SETTLE_CYC = (SETTLE_OSC * CLK_KHZ + OSC_KHZ - 1) / OSC_KHZ;
  localparam int CNT_W = 10;
  // synchroniser lanes
  localparam int SYNC_W = 6;
  localparam int I_BTN_N = 0;
  localparam int I_ALARM = 1;
  localparam int I_MAIN = 2;
  localparam int I_BKLOW = 3;
  localparam int I_FAULT = 4;
  localparam int I_HS = 5;
  // sequencer states
  typedef enum logic [2:0] {
    S_BACKUP = 3'b000,
    S_STANDBY = 3'b001,
    S_RAMP = 3'b010,
    S_LATCH = 3'b011,
    S_NORMAL = 3'b100,
    S_PG_OFF = 3'b101,
    S_OFF = 3'b110
  } pss_state_t;
endpackage : pss_pkg

// *** design/pss_sync.sv ***
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module pss_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [W-1:0] d_async,
  output logic [W-1:0] q
);
  // first stage, read only by the second stage
  logic [W-1:0] meta_q;

  // both stages freeze with the clock enable like all other state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_q <= d_async;
      q <= meta_q;
    end
  end
endmodule : pss_sync

// *** design/pss_seq.sv ***
// power start-up/shut-down sequencer with apb register slave
// Notes on behaviour
// RULE_01: backup cell only: supplies off, clock runs
// RULE_02: battery above threshold: charge backup, standby
// RULE_03: reset clock only if backup was low
// RULE_04: button or alarm starts sequence in standby
// RULE_05: sequence done: release power good, normal
// RULE_06: pushbutton wake by default, switch as option
// RULE_07: variant fixes order and default settings
// RULE_08: static: low battery or fault powers off
// RULE_09: static: drop power good, await handshake
// RULE_10: dynamic: fault or software request powers off
// RULE_11: dynamic: low battery only raises interrupt
// RULE_12: host writes shutdown register to power off
// RULE_13: dynamic shutdown: drop power good, then supplies
// RULE_14: wait for button release after shutdown
// RULE_15: fault or low battery signalled by interrupt
// RULE_16: unsequenced supply waits for user command
// RULE_17: static: latch handshake before power good
// RULE_18: one supply per step, settle count between
// RULE_19: button and alarm synchronised before use
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
module pss_seq #(
  parameter bit P_DYNAMIC = 1'b1,
  parameter bit P_SWITCH = 1'b0,
  parameter logic [5:0] P_ORDER = 6'h2D,
  parameter logic [31:0] P_VSET = 32'h00000000,
  parameter int P_SETTLE = pss_pkg::SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_btn_n,
  input wire logic rtc_alarm,
  input wire logic main_above_th,
  input wire logic backup_low,
  input wire logic short_fault,
  input wire logic irq_handshake_pin_i,
  output logic irq_handshake_pin_o,
  output logic irq_handshake_pin_oe_n,
  output logic power_good_out_o,
  output logic power_good_out_oe_n,
  output logic fault_irq_out,
  output logic [3:0] supply_en,
  output logic [31:0] supply_vset,
  output logic backup_charge_en,
  output logic rtc_reset
);
  localparam int CW = pss_pkg::CNT_W;
  // last count of a settle interval
  localparam logic [CW-1:0] SETTLE_LAST = CW'(P_SETTLE - 1);

  pss_pkg::pss_state_t state_q; // sequencer state
  logic [CW-1:0] cnt_q; // settle counter
  logic [1:0] step_q; // current start-up step
  logic pg_q; // power good released
  logic [3:0] sup_q; // supply enables
  logic charge_q; // backup charge switch
  logic rtc_rst_q; // one-cycle clock reset
  logic hs_latch_q; // handshake level caught at start-up end
  logic lowbat_q; // sticky low battery flag
  logic fault_q; // sticky converter fault flag
  logic late_en_q; // software enable of unsequenced supplies
  logic [31:0] vset_q; // supply output settings
  logic [31:0] prdata_q; // read data captured in setup
  logic [5:0] s; // synchronised pin levels
  logic [3:0] seq_mask; // supplies covered by the sequence
  logic btn_pressed, wake, main_ok, fault, hs;
  logic hit, wr, sw_off, sw_open, off_cond, clr_lb, clr_ft;
  logic [1:0] first_sup, next_sup;

  // every asynchronous pin passes two flops first [RULE_19]
  pss_sync #(.W(pss_pkg::SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .d_async({irq_handshake_pin_i, short_fault, backup_low,
              main_above_th, rtc_alarm, wake_btn_n}),
    .q(s)
  );

  // decoded pin levels
  assign btn_pressed = ~s[pss_pkg::I_BTN_N];
  assign wake = btn_pressed | s[pss_pkg::I_ALARM]; // [RULE_04] [RULE_06]
  assign main_ok = s[pss_pkg::I_MAIN];
  assign fault = s[pss_pkg::I_FAULT];
  assign hs = s[pss_pkg::I_HS];

  // supplies picked by the variant order [RULE_07]
  assign first_sup = P_ORDER[1:0];
  assign next_sup = P_ORDER[{step_q + 2'h1, 1'b0} +: 2];

  // mask of sequenced supplies, the rest wait for software
  always_comb begin
    seq_mask = '0;
    for (int i = 0; i <= int'(pss_pkg::LAST_STEP); i++) begin
      seq_mask[P_ORDER[2*i +: 2]] = 1'b1;
    end
  end

  // apb decode; the slave answers in the first access cycle
  assign hit = (paddr == pss_pkg::REG_CTRL) |
               (paddr == pss_pkg::REG_STATUS) |
               (paddr == pss_pkg::REG_VSET);
  assign pready = clk_en;
  assign pslverr = psel & penable & ~hit;
  assign wr = psel & penable & pwrite & clk_en & hit;
  assign clr_lb = wr & (paddr == pss_pkg::REG_STATUS) &
                  pwdata[pss_pkg::ST_LOWBAT];
  assign clr_ft = wr & (paddr == pss_pkg::REG_STATUS) &
                  pwdata[pss_pkg::ST_FAULT];

  // software shutdown request, written by the host [RULE_12]
  assign sw_off = wr & (paddr == pss_pkg::REG_CTRL) &
                  pwdata[pss_pkg::CTRL_SHUTDOWN];
  // in dynamic mode a latching switch opened counts as an off request [RULE_06]
  assign sw_open = P_SWITCH & ~btn_pressed;

  // power-off condition differs by management mode
  always_comb begin
    if (P_DYNAMIC) begin
      off_cond = fault | sw_off | sw_open; // [RULE_10] [RULE_11]
    end else begin
      off_cond = ~main_ok | fault; // [RULE_08]
    end
  end

  // main sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pss_pkg::S_BACKUP;
      cnt_q <= '0;
      step_q <= '0;
      pg_q <= 1'b0;
      sup_q <= '0;
      charge_q <= 1'b0;
      rtc_rst_q <= 1'b0;
      hs_latch_q <= 1'b0;
    end else if (clk_en) begin
      rtc_rst_q <= 1'b0;
      unique case (state_q)
        // backup cell only: keep everything off [RULE_01]
        pss_pkg::S_BACKUP: begin
          sup_q <= '0;
          charge_q <= 1'b0;
          if (main_ok) begin
            charge_q <= 1'b1; // [RULE_02]
            rtc_rst_q <= s[pss_pkg::I_BKLOW]; // [RULE_03]
            state_q <= pss_pkg::S_STANDBY;
          end
        end
        // wait for a wake request, no command needed [RULE_04]
        pss_pkg::S_STANDBY: begin
          if (!main_ok) begin
            charge_q <= 1'b0;
            state_q <= pss_pkg::S_BACKUP;
          end else if (wake) begin
            sup_q[first_sup] <= 1'b1; // [RULE_18]
            step_q <= '0;
            cnt_q <= '0;
            state_q <= pss_pkg::S_RAMP;
          end
        end
        // one supply per step, settle between steps [RULE_18]
        pss_pkg::S_RAMP: begin
          if (cnt_q == SETTLE_LAST) begin
            cnt_q <= '0;
            if (step_q == pss_pkg::LAST_STEP) begin
              state_q <= pss_pkg::S_LATCH;
            end else begin
              sup_q[next_sup] <= 1'b1;
              step_q <= step_q + 2'h1;
            end
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        // catch the handshake level, then power good [RULE_17]
        pss_pkg::S_LATCH: begin
          hs_latch_q <= hs;
          pg_q <= 1'b1; // [RULE_05]
          state_q <= pss_pkg::S_NORMAL;
        end
        // running; late supplies only on software command
        pss_pkg::S_NORMAL: begin
          if (P_DYNAMIC && late_en_q) begin
            sup_q <= sup_q | ~seq_mask; // [RULE_16]
          end
          if (off_cond) begin
            pg_q <= 1'b0; // [RULE_09] [RULE_13]
            state_q <= pss_pkg::S_PG_OFF;
          end
        end
        // power good is low; static waits for host handshake
        pss_pkg::S_PG_OFF: begin
          if (P_DYNAMIC || !hs) begin
            sup_q <= '0; // [RULE_09] [RULE_13]
            state_q <= pss_pkg::S_OFF;
          end
        end
        // no new wake until the button is released [RULE_14]
        pss_pkg::S_OFF: begin
          if (!btn_pressed) begin
            if (main_ok) begin
              state_q <= pss_pkg::S_STANDBY;
            end else begin
              charge_q <= 1'b0;
              state_q <= pss_pkg::S_BACKUP;
            end
          end
        end
        // unused code: recover to backup with supplies and power good off
        default: begin
          sup_q <= '0;
          pg_q <= 1'b0;
          state_q <= pss_pkg::S_BACKUP;
        end
      endcase
    end
  end

  // sticky event flags, a new event beats a clear [RULE_15]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowbat_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (clk_en) begin
      lowbat_q <= (lowbat_q & ~clr_lb) | (~main_ok & (sup_q != '0));
      fault_q <= (fault_q & ~clr_ft) | fault;
    end
  end

  // software-owned control and settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      late_en_q <= 1'b0;
      vset_q <= P_VSET; // [RULE_07]
    end else if (wr) begin
      if (paddr == pss_pkg::REG_CTRL) begin
        late_en_q <= pwdata[pss_pkg::CTRL_LATE_EN];
      end
      // static parts keep the variant defaults [RULE_07]
      if (P_DYNAMIC && paddr == pss_pkg::REG_VSET) begin
        vset_q <= pwdata;
      end
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata_q <= '0;
      if (paddr == pss_pkg::REG_CTRL) begin
        prdata_q[pss_pkg::CTRL_LATE_EN] <= late_en_q;
      end else if (paddr == pss_pkg::REG_STATUS) begin
        prdata_q[pss_pkg::ST_LOWBAT] <= lowbat_q;
        prdata_q[pss_pkg::ST_FAULT] <= fault_q;
        prdata_q[pss_pkg::ST_PG] <= pg_q;
        prdata_q[pss_pkg::ST_HS] <= hs_latch_q;
        prdata_q[pss_pkg::ST_STATE +: 3] <= state_q;
      end else if (paddr == pss_pkg::REG_VSET) begin
        prdata_q <= vset_q;
      end
    end
  end

  // outputs; open-drain pins only ever pull low
  assign prdata = prdata_q;
  assign supply_en = sup_q;
  assign supply_vset = vset_q;
  assign backup_charge_en = charge_q;
  assign rtc_reset = rtc_rst_q;
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe_n = pg_q; // [RULE_05]
  assign fault_irq_out = lowbat_q | fault_q; // [RULE_15]
  assign irq_handshake_pin_o = 1'b0;
  // static parts use the pin as handshake input, never drive it
  assign irq_handshake_pin_oe_n = ~(P_DYNAMIC & (lowbat_q | fault_q));

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_off_req;
    clk_en && state_q == pss_pkg::S_NORMAL && off_cond;
  endsequence
  sequence s_pg_first;
    !pg_q && sup_q != '0 && state_q == pss_pkg::S_PG_OFF;
  endsequence

  a_backup_all_off: assert property ( // [RULE_01]
    state_q == pss_pkg::S_BACKUP && clk_en |=> sup_q == '0 && !pg_q)
    else $error("supply on in backup mode");
  a_standby_charge: assert property ( // [RULE_02]
    clk_en && state_q == pss_pkg::S_BACKUP && main_ok |=>
      state_q == pss_pkg::S_STANDBY && charge_q)
    else $error("no standby entry on good battery");
  a_rtc_reset_cause: assert property ( // [RULE_03]
    rtc_rst_q |-> $past(s[pss_pkg::I_BKLOW]) &&
      $past(state_q) == pss_pkg::S_BACKUP)
    else $error("clock reset without low backup cell");
  a_wake_starts: assert property ( // [RULE_04]
    clk_en && state_q == pss_pkg::S_STANDBY && main_ok && wake |=>
      state_q == pss_pkg::S_RAMP && sup_q == 4'(1 << first_sup))
    else $error("wake did not start sequence");
  a_pg_only_normal: assert property ( // [RULE_05]
    power_good_out_oe_n |-> state_q == pss_pkg::S_NORMAL &&
      (sup_q & seq_mask) == seq_mask)
    else $error("power good outside normal mode");
  a_step_settle: assert property ( // [RULE_18]
    $past(state_q) == pss_pkg::S_RAMP && $changed(sup_q) |->
      $past(cnt_q) == SETTLE_LAST && cnt_q == '0)
    else $error("supply enabled before settle count");
  a_pg_before_off: assert property ( // [RULE_09]
    s_off_req |=> s_pg_first)
    else $error("power good not cleared first");
  a_static_waits: assert property ( // [RULE_09]
    !P_DYNAMIC && clk_en && state_q == pss_pkg::S_PG_OFF && hs |=>
      state_q == pss_pkg::S_PG_OFF && sup_q != '0)
    else $error("static shutdown ignored handshake");
  a_dyn_lowbat: assert property ( // [RULE_11]
    P_DYNAMIC && clk_en && state_q == pss_pkg::S_NORMAL && !main_ok &&
      !fault && !sw_off && !sw_open |=>
      state_q == pss_pkg::S_NORMAL ##1 !irq_handshake_pin_oe_n)
    else $error("low battery handled wrongly in dynamic mode");
  a_release_wait: assert property ( // [RULE_14]
    clk_en && state_q == pss_pkg::S_OFF && btn_pressed |=>
      state_q == pss_pkg::S_OFF)
    else $error("left off state with button held");
  a_latch_then_pg: assert property ( // [RULE_17]
    clk_en && state_q == pss_pkg::S_LATCH |=>
      pg_q && hs_latch_q == $past(hs))
    else $error("handshake not latched with power good");
endmodule : pss_seq

// *** bench/pss_host_model.sv ***
// host microcontroller and wake pushbutton facing the sequencer pins
`timescale 1ns/100ps
module pss_host_model (
  input wire logic press,
  input wire logic hs_pull,
  input wire logic pg_oe_n,
  input wire logic irq_oe_n,
  input wire logic pg_o,
  input wire logic irq_o,
  output logic wake_btn_n,
  output logic hs_pin,
  output logic pg_pin
);
  // pad pull-up keeps the wake line high while the button is up
  assign wake_btn_n = press ? 1'b0 : 1'b1;
  // shared open-drain wire: host pull, device level, else pull-up
  assign hs_pin = hs_pull ? 1'b0 : (irq_oe_n ? 1'b1 : irq_o);
  // host reset line rises through its pull-up once released
  assign pg_pin = pg_oe_n ? 1'b1 : pg_o;
endmodule : pss_host_model

// *** bench/pss_seq_bench.sv ***
// self-checking bench for the power start-up/shut-down sequencer
`timescale 1ns/100ps
module pss_seq_bench;
  localparam int SET = 4; // short settle count keeps the run brief
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, supply_vset, vset_v;
  logic rtc_alarm, main_above_th, backup_low, short_fault, press, hs_pull;
  logic wake_btn_n, hs_pin, pg_pin, irq_oe_n, pg_oe_n, fault_irq_out;
  logic [3:0] supply_en;
  logic backup_charge_en, rtc_reset, clk_en, pg_o, irq_o, pg_s;
  logic [3:0] sup_s; // supplies of the static-mode twin
  logic [32:0] exp_q[$]; // expected {pslverr, prdata} per read
  logic [32:0] msk_q[$]; // bits of each read that matter
  int fail_count, checks, seed, n, rtc_cnt;

  pss_seq #(.P_SETTLE(SET)) DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_btn_n(wake_btn_n), .rtc_alarm(rtc_alarm),
    .main_above_th(main_above_th), .backup_low(backup_low),
    .short_fault(short_fault), .irq_handshake_pin_i(hs_pin),
    .irq_handshake_pin_o(irq_o), .irq_handshake_pin_oe_n(irq_oe_n),
    .power_good_out_o(pg_o), .power_good_out_oe_n(pg_oe_n),
    .fault_irq_out(fault_irq_out), .supply_en(supply_en),
    .supply_vset(supply_vset), .backup_charge_en(backup_charge_en),
    .rtc_reset(rtc_reset));

  // static-mode twin on the same pins; its handshake is the host pull
  pss_seq #(.P_DYNAMIC(1'b0), .P_SETTLE(SET)) DUT_S (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(),
    .wake_btn_n(wake_btn_n), .rtc_alarm(rtc_alarm),
    .main_above_th(main_above_th), .backup_low(backup_low),
    .short_fault(short_fault), .irq_handshake_pin_i(!hs_pull),
    .irq_handshake_pin_o(), .irq_handshake_pin_oe_n(),
    .power_good_out_o(), .power_good_out_oe_n(pg_s),
    .fault_irq_out(), .supply_en(sup_s), .supply_vset(),
    .backup_charge_en(), .rtc_reset());

  pss_host_model host (.press(press), .hs_pull(hs_pull),
    .pg_oe_n(pg_oe_n), .irq_oe_n(irq_oe_n), .wake_btn_n(wake_btn_n),
    .pg_o(pg_o), .irq_o(irq_o),
    .hs_pin(hs_pin), .pg_pin(pg_pin));

  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // one comparison, counted, reported at once on mismatch
  task chk(input string nm, input logic [32:0] seen, input logic [32:0] e);
    checks++;
    if (seen !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, seen);
    end
  endtask : chk

  // apb transfer; a read leaves its expectation in the queue
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e, input logic [32:0] m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read the state field of the status word
  task st(input logic [2:0] s);
    apb(1'b0, pss_pkg::REG_STATUS, 32'h0, 33'({s, 4'h0}), 33'h70);
  endtask : st

  // wait k edges, then let their updates land
  task tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : tick

  // edges until the supply or power-good pins next move
  task wchg(output int k);
    logic [4:0] o;
    o = {supply_en, pg_oe_n};
    k = 0;
    do begin
      tick(1);
      k++;
    end while ({supply_en, pg_oe_n} === o && k < 300);
  endtask : wchg

  // whole start-up after a wake event
  task ramp_up();
    wchg(n);
    chk("step0", 33'(supply_en), 33'h2);
    wchg(n);
    chk("gap1", 33'(n), 33'(SET));
    chk("step1", 33'(supply_en), 33'hA);
    wchg(n);
    chk("gap2", 33'(n), 33'(SET));
    chk("step2", 33'(supply_en), 33'hE);
    wchg(n);
    chk("pg gap", 33'(n), 33'(SET + 1));
    chk("pg", 33'({pg_pin, supply_en}), 33'h1E);
  endtask : ramp_up

  task done_t(input string s);
    $display("test %s done", s);
  endtask : done_t

  task finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // takes the oldest note as each read completes
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && msk_q.size() > 0) begin
      chk("read", {pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
    end
    // counts clock-reset pulses; one driver only
    if (!presetn) begin
      rtc_cnt <= 0;
    end else if (rtc_reset === 1'b1) begin
      rtc_cnt <= rtc_cnt + 1;
    end
  end

  // cuts a hang far beyond the under 150 cycles needed
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  initial begin
    seed = 86;
    fail_count = 0;
    checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rtc_alarm, main_above_th, short_fault, press, hs_pull} = '0;
    backup_low = 1'b1;
    clk_en = 1'b1;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    tick(4);
    chk("backup", 33'({pg_pin, supply_en, backup_charge_en}), 33'h0);
    st(3'h0);
    main_above_th <= 1'b1;
    tick(5);
    chk("charge", 33'(backup_charge_en), 33'h1);
    chk("rtc reset", 33'(rtc_cnt), 33'h1);
    st(3'h1);
    done_t("insert");
    press <= 1'b1;
    ramp_up();
    press <= 1'b0;
    st(3'h4);
    done_t("button wake");
    vset_v = $random(seed);
    apb(1'b1, pss_pkg::REG_VSET, vset_v, 33'h0, 33'h0);
    apb(1'b0, pss_pkg::REG_VSET, 32'h0, {1'b0, vset_v}, '1);
    tick(1);
    chk("vset", 33'(supply_vset), 33'(vset_v));
    apb(1'b0, 8'h3C, 32'h0, 33'h100000000, '1);
    apb(1'b1, pss_pkg::REG_CTRL, 32'h2, 33'h0, 33'h0);
    tick(2);
    chk("late", 33'(supply_en), 33'hF);
    done_t("registers");
    main_above_th <= 1'b0;
    tick(5);
    chk("lowbat", 33'({fault_irq_out, hs_pin, supply_en}), 33'h2F);
    chk("static hold", 33'({pg_s, sup_s}), 33'hE);
    hs_pull <= 1'b1; // host answers the static handshake
    main_above_th <= 1'b1;
    tick(4);
    chk("static off", 33'({pg_s, sup_s}), 33'h0);
    hs_pull <= 1'b0;
    apb(1'b1, pss_pkg::REG_STATUS, 32'h3, 33'h0, 33'h0);
    tick(2);
    chk("clear", 33'({fault_irq_out, hs_pin}), 33'h1);
    press <= 1'b1;
    apb(1'b1, pss_pkg::REG_CTRL, 32'h1, 33'h0, 33'h0);
    #1;
    chk("pg first", 33'({pg_pin, supply_en[1]}), 33'h1);
    tick(1);
    chk("off", 33'({pg_pin, supply_en}), 33'h0);
    tick(10);
    st(3'h6);
    press <= 1'b0;
    tick(5);
    st(3'h1);
    done_t("shutdown");
    rtc_alarm <= 1'b1;
    ramp_up();
    rtc_alarm <= 1'b0;
    short_fault <= 1'b1;
    tick(5);
    chk("fault", 33'({fault_irq_out, hs_pin, pg_pin, supply_en}), 33'h40);
    short_fault <= 1'b0;
    tick(2);
    apb(1'b1, pss_pkg::REG_STATUS, 32'h3, 33'h0, 33'h0);
    tick(5);
    done_t("alarm and fault");
    main_above_th <= 1'b0;
    backup_low <= 1'b0;
    tick(5);
    st(3'h0);
    chk("no charge", 33'(backup_charge_en), 33'h0);
    clk_en <= 1'b0; // frozen: the insertion must not be acted on
    main_above_th <= 1'b1;
    tick(6);
    chk("frozen", 33'({backup_charge_en, supply_en}), 33'h0);
    clk_en <= 1'b1;
    tick(6);
    chk("charge back", 33'(backup_charge_en), 33'h1);
    chk("keep clock", 33'(rtc_cnt), 33'h1);
    done_t("reinsert");
    finish_test();
  end
endmodule : pss_seq_bench
